// ---- verilog/phy_irq_pkg.sv ----
// constants for the phy interrupt and control block
package phy_irq_pkg;

  // ----------------------------------------
  // register map (index, byte address = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] phy_specific_control_idx = 8'h11;
  localparam logic [7:0] interrupt_status_one_idx = 8'h12;
  localparam logic [9:0] phy_specific_control_addr =
    {phy_specific_control_idx, 2'b00};
  localparam logic [9:0] interrupt_status_one_addr =
    {interrupt_status_one_idx, 2'b00};

  // ----------------------------------------
  // phy_specific_control fields
  // ----------------------------------------
  localparam int lb_depth_lsb = 8;
  localparam int col_fd_en_bit = 4;
  localparam int irq_pol_bit = 3;
  localparam int irq_test_bit = 2;
  localparam int irq_global_en_bit = 1;
  localparam int irq_out_en_bit = 0;
  localparam logic [1:0] lb_depth_reset = 2'h1;
  localparam logic irq_pol_reset = 1'b1;

  // ----------------------------------------
  // interrupt_status_one fields
  // ----------------------------------------
  localparam int status_lsb = 8;
  localparam int num_events = 8;
  localparam int ev_link_quality = 7;
  localparam int ev_energy = 6;
  localparam int ev_link_status = 5;
  localparam int ev_speed = 4;
  localparam int ev_duplex = 3;
  localparam int ev_an_done = 2;
  localparam int ev_fc_half = 1;
  localparam int ev_rx_err_half = 0;

  // ----------------------------------------
  // loopback fifo depth codes, in nibbles
  // ----------------------------------------
  localparam logic [3:0] lb_depth_00 = 4'h4;
  localparam logic [3:0] lb_depth_01 = 4'h5;
  localparam logic [3:0] lb_depth_10 = 4'h6;
  localparam logic [3:0] lb_depth_11 = 4'h8;
  localparam int lb_fifo_words = 8;

endpackage : phy_irq_pkg

// ---- verilog/phy_interrupt_control.sv ----
// interrupt, collision and loopback fifo control with apb registers
//
// Operation
// RULE_01 - loopback depth codes 00..11 give 4,5,6,8 nibbles; reset code 01
// RULE_02 - in far-end loopback, data passes through fifo of selected depth
// RULE_03 - full-duplex collision enable lets collision through in full duplex
// RULE_04 - half duplex always passes collision regardless of enable bit
// RULE_05 - polarity 1 idles pin high, low on interrupt; 0 inverts
// RULE_06 - test bit forces an interrupt continuously while set
// RULE_07 - global enable gates events, each qualified by its own enable
// RULE_08 - output enable drives pin as interrupt; clear makes it power-down in
// RULE_09 - status bit 15 latches on link quality change while link up
// RULE_10 - status bit 14 latches on any energy detect change
// RULE_11 - status bit 13 latches on any link status change
// RULE_12 - status bit 12 latches on any speed change
// RULE_13 - status bit 11 latches on any duplex change
// RULE_14 - status bit 10 latches when auto-negotiation completes
// RULE_15 - status bit 9 latches when false carrier counter passes half
// RULE_16 - status bit 8 latches when receive error counter passes half
// RULE_17 - enable bits 7 and 6 reset 0, gate link quality and energy
// RULE_18 - enable bit 5 resets 0, gates link status change interrupt
// RULE_19 - reading status clears latched bits unless event recurs same cycle
// RULE_20 - pin asserts if output enabled and test or enabled pending event
`timescale 1ns/1ps

module phy_interrupt_control
  import phy_irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // phy state inputs
  input wire logic link_up,
  input wire logic link_quality_good,
  input wire logic energy_detected,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic an_complete,
  input wire logic fc_count_half,
  input wire logic rx_err_count_half,
  // collision toward the mac
  input wire logic col_in,
  output logic col_out,
  // far-end loopback path
  input wire logic loopback_active,
  input wire logic [3:0] rx_nibble,
  input wire logic rx_nibble_valid,
  input wire logic tx_nibble_strobe,
  output logic [3:0] tx_nibble,
  output logic tx_nibble_valid,
  // shared interrupt / power-down pin
  input wire logic irq_or_powerdown_pin_in,
  output logic irq_or_powerdown_pin_out,
  output logic irq_or_powerdown_pin_oe,
  output logic power_down
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0] lb_depth;
  logic col_fd_en;
  logic irq_pol;
  logic irq_test;
  logic irq_global_en;
  logic irq_out_en;
  logic [num_events-1:0] status;
  logic [num_events-1:0] event_en;
  logic [num_events-1:0] read_mask;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // full 10-bit compare, so aliases of the two registers answer as unmapped
  wire hit_ctrl = (paddr == phy_specific_control_addr);
  wire hit_stat = (paddr == interrupt_status_one_addr);
  wire acc_first = psel & penable & ~pready;
  wire acc_done = psel & penable & pready;
  wire wr_ctrl = acc_done & pwrite & hit_ctrl;
  wire wr_stat = acc_done & pwrite & hit_stat;
  wire rd_stat_done = acc_done & ~pwrite & hit_stat;

  wire [15:0] ctrl_word = {6'h00, lb_depth, 3'h0, col_fd_en, irq_pol,
                           irq_test, irq_global_en, irq_out_en};
  // latched events in the upper byte, their enables below
  wire [15:0] stat_word = {status, event_en};
  wire [31:0] next_prdata = hit_ctrl ? {16'h0000, ctrl_word} :
                            hit_stat ? {16'h0000, stat_word} :
                            32'h0000_0000;

  // answer one cycle into the access phase, so every transfer takes 3 cycles;
  // the wait state lets read data and the clear mask come from one sample
  wire unmapped = ~hit_ctrl & ~hit_stat;
  wire rd_capture = acc_first & ~pwrite;

  // unmapped accesses still complete, with an error and zero data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc_first;
      pslverr <= acc_first & unmapped;
    end
  end

  // read data holds after the transfer until the next read is captured
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (rd_capture)
      prdata <= next_prdata;
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lb_depth <= lb_depth_reset; // RULE_01
      col_fd_en <= 1'b0;
      irq_pol <= irq_pol_reset; // RULE_05
      irq_test <= 1'b0;
      irq_global_en <= 1'b0;
      irq_out_en <= 1'b0; // RULE_08
    end
    // bits outside the listed fields are dropped and read back as zero
    else if (wr_ctrl)
    begin
      lb_depth <= pwdata[lb_depth_lsb +: 2];
      col_fd_en <= pwdata[col_fd_en_bit];
      irq_pol <= pwdata[irq_pol_bit];
      irq_test <= pwdata[irq_test_bit];
      irq_global_en <= pwdata[irq_global_en_bit];
      irq_out_en <= pwdata[irq_out_en_bit];
    end
  end

  // ----------------------------------------
  // event detection
  // ----------------------------------------
  // the previous samples are primed one cycle after reset so that levels
  // already present at reset release do not fake a change
  logic primed;
  logic [num_events-1:0] prev;
  // bit order of cur matches the status field, msb first
  wire [num_events-1:0] cur = {link_quality_good, energy_detected, link_up,
                               speed_100, full_duplex, an_complete,
                               fc_count_half, rx_err_count_half};
  wire [num_events-1:0] changed = cur ^ prev;
  wire [num_events-1:0] rose = cur & ~prev;
  // negotiation and half-full events latch on the rise only; a falling
  // input is no news to software
  wire [num_events-1:0] raw_event = {
    changed[ev_link_quality] & link_up, // RULE_09
    changed[ev_energy], // RULE_10
    changed[ev_link_status], // RULE_11
    changed[ev_speed], // RULE_12
    changed[ev_duplex], // RULE_13
    rose[ev_an_done], // RULE_14
    rose[ev_fc_half], // RULE_15
    rose[ev_rx_err_half] // RULE_16
  };
  // nothing is reported in the first cycle after reset release
  wire [num_events-1:0] events = primed ? raw_event : {num_events{1'b0}};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      primed <= 1'b0;
    else
      primed <= 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prev <= {num_events{1'b0}};
    else
      prev <= cur;
  end

  // ----------------------------------------
  // latched status and enables
  // ----------------------------------------
  // only bits returned to software are cleared, so an event landing
  // between the data capture and the end of the access is kept
  wire [num_events-1:0] clr_mask =
    rd_stat_done ? read_mask : {num_events{1'b0}};

  // a set in the clearing cycle wins over the clear
  wire [num_events-1:0] next_status = (status & ~clr_mask) | events;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      status <= {num_events{1'b0}};
    else
      status <= next_status; // RULE_19
  end

  // the mask is taken with the read data, so exactly what was returned
  // is what the end of the access clears
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      read_mask <= {num_events{1'b0}};
    else if (rd_capture && hit_stat)
      read_mask <= status;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      event_en <= {num_events{1'b0}}; // RULE_17 RULE_18
    // enable bit n gates status bit n+8, the five low enables included
    else if (wr_stat)
      event_en <= pwdata[num_events-1:0];
  end

  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  // the test bit skips the global enable, so the pin path can be checked
  // with every event masked
  wire any_enabled = |(status & event_en); // RULE_07
  wire irq_active = irq_out_en & // RULE_20
                    (irq_test | (irq_global_en & any_enabled)); // RULE_06
  wire next_pin_out = irq_pol ? ~irq_active : irq_active; // RULE_05
  // the pin is active low when used as a power-down input
  wire next_power_down = ~irq_out_en & ~irq_or_powerdown_pin_in; // RULE_08

  // the pin idles at the reset polarity level, so the host sees no false
  // interrupt while the enables are still being written
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_or_powerdown_pin_out <= irq_pol_reset;
      irq_or_powerdown_pin_oe <= 1'b0;
    end
    else
    begin
      irq_or_powerdown_pin_out <= next_pin_out; // RULE_05
      irq_or_powerdown_pin_oe <= irq_out_en; // RULE_08
    end
  end

  // power-down follows the pin a cycle late; a low pin level while the
  // output is enabled is our own interrupt and is ignored
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      power_down <= 1'b0;
    else
      power_down <= next_power_down; // RULE_08
  end

  // ----------------------------------------
  // collision
  // ----------------------------------------
  // col_in is a raw level; one register of delay keeps col_out glitch free
  wire next_col = col_in & (~full_duplex | col_fd_en); // RULE_03 RULE_04

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      col_out <= 1'b0;
    else
      col_out <= next_col;
  end

  // ----------------------------------------
  // far-end loopback fifo
  // ----------------------------------------
  // unknown codes fall back to the reset depth
  function automatic logic [3:0] depth_of(input logic [1:0] code);
    case (code)
      2'h0: depth_of = lb_depth_00;
      2'h1: depth_of = lb_depth_01;
      2'h2: depth_of = lb_depth_10;
      2'h3: depth_of = lb_depth_11;
      default: depth_of = lb_depth_01;
    endcase
  endfunction : depth_of

  logic [3:0] lb_mem [lb_fifo_words];
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  logic [3:0] fill;
  logic draining;

  wire [3:0] depth = depth_of(lb_depth); // RULE_01
  wire fifo_full = (fill == 4'(lb_fifo_words));
  wire fifo_empty = (fill == 4'h0);
  // leaving loopback flushes the fifo, so a new session starts empty
  wire flush = ~loopback_active;
  // reading starts only once the selected slack is built up, so a slow
  // receive clock does not starve the transmit side mid-frame
  wire do_wr = loopback_active & rx_nibble_valid & ~fifo_full;
  wire do_rd = loopback_active & tx_nibble_strobe & draining & ~fifo_empty;
  wire next_draining = loopback_active & ~fifo_empty &
                       (draining | (fill >= depth)); // RULE_02
  wire [3:0] next_fill = flush ? 4'h0 :
                         fill + {3'h0, do_wr} - {3'h0, do_rd};
  wire [2:0] next_wr_ptr = flush ? 3'h0 : wr_ptr + {2'h0, do_wr};
  wire [2:0] next_rd_ptr = flush ? 3'h0 : rd_ptr + {2'h0, do_rd};
  // the transmit register holds its nibble between strobes
  wire [3:0] next_tx_nibble = flush ? 4'h0 :
                              do_rd ? lb_mem[rd_ptr] : tx_nibble; // RULE_02

  // storage has no reset; only pointers and fill count need one
  always_ff @(posedge clk)
  begin
    if (do_wr)
      lb_mem[wr_ptr] <= rx_nibble;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fill <= 4'h0;
      draining <= 1'b0;
    end
    else
    begin
      fill <= next_fill;
      draining <= next_draining;
    end
  end

  // output stage kept apart so the transmit side sees a clean register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_nibble <= 4'h0;
      tx_nibble_valid <= 1'b0;
    end
    else
    begin
      tx_nibble <= next_tx_nibble;
      tx_nibble_valid <= do_rd; // RULE_02
    end
  end

endmodule : phy_interrupt_control

// ---- tb/phy_irq_checker.sv ----
// assertion checker for the phy interrupt control block
`timescale 1ns/1ps

module phy_irq_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic full_duplex,
  input wire logic col_in,
  input wire logic col_out,
  input wire logic tx_nibble_strobe,
  input wire logic tx_nibble_valid,
  input wire logic irq_or_powerdown_pin_in,
  input wire logic irq_or_powerdown_pin_oe,
  input wire logic power_down
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_RDY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after wait state");
  AST_RDY_REQ: assert property (pready |-> psel && penable)
    else $error("pready without request");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_COL_HD: assert property (col_in && !full_duplex |=> col_out)
    else $error("collision lost in half duplex");
  AST_COL_CAUSE: assert property (col_out |-> $past(col_in))
    else $error("collision without cause");
  AST_PD_CAUSE: assert property ($rose(power_down) |->
    $past(!irq_or_powerdown_pin_in && !irq_or_powerdown_pin_oe))
    else $error("power down without low input pin");
  AST_LB_VALID: assert property (tx_nibble_valid |->
    $past(tx_nibble_strobe))
    else $error("nibble valid without strobe");
endmodule : phy_irq_checker

bind phy_interrupt_control phy_irq_checker i_phy_irq_checker (.clk, .nrst,
  .psel, .penable, .pready, .pslverr, .full_duplex, .col_in, .col_out,
  .tx_nibble_strobe, .tx_nibble_valid, .irq_or_powerdown_pin_in,
  .irq_or_powerdown_pin_oe, .power_down);

// ---- tb/phy_pin_host.sv ----
// host side of the shared interrupt / power-down pin
`timescale 1ns/1ps

module phy_pin_host (
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic pd_req,
  output logic pin_level
);
  // pulled up when undriven; the host pulls low to request power-down
  assign pin_level = pin_oe ? pin_out : !pd_req;
endmodule : phy_pin_host

// ---- tb/test_phy_interrupt_control.sv ----
// self-checking testbench for the phy interrupt control block
`timescale 1ns/1ps

module test_phy_interrupt_control;
  import phy_irq_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, col_in = 0, col_out, lb = 0, rxv = 0, txs = 0;
  logic [3:0] rxn = '0, txn;
  logic txv, pin, pin_oe, pin_out, pd, pd_req = 0;
  logic [7:0] ev = '0;
  int error_cnt = 0, cmp_count = 0;

  always #5 clk = ~clk;

  phy_interrupt_control i_phy_interrupt_control (.clk, .nrst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link_up(ev[5]), .link_quality_good(ev[7]), .energy_detected(ev[6]),
    .speed_100(ev[4]), .full_duplex(ev[3]), .an_complete(ev[2]),
    .fc_count_half(ev[1]), .rx_err_count_half(ev[0]), .col_in, .col_out,
    .loopback_active(lb), .rx_nibble(rxn), .rx_nibble_valid(rxv),
    .tx_nibble_strobe(txs), .tx_nibble(txn), .tx_nibble_valid(txv),
    .irq_or_powerdown_pin_in(pin), .irq_or_powerdown_pin_out(pin_out),
    .irq_or_powerdown_pin_oe(pin_oe), .power_down(pd));
  phy_pin_host i_phy_pin_host (.pin_oe, .pin_out, .pd_req, .pin_level(pin));

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20)
      chk("pready", 1, 0);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb

  task rd(input logic [9:0] a, input logic [31:0] exp, input string nm);
    apb(0, a, 0);
    chk(nm, exp, r);
  endtask : rd

  // fixed wait: every path registers at most twice; outputs are read at
  // the third edge, before it updates them, and new stimulus starts there
  task settle;
    repeat (3) @(posedge clk);
  endtask : settle

  task lb_feed(input int n);
    for (int i = 1; i <= n; i++)
    begin
      rxn <= i[3:0];
      rxv <= 1;
      @(posedge clk);
    end
    rxv <= 0;
    repeat (2) @(posedge clk);
  endtask : lb_feed

  task lb_strobe;
    txs <= 1;
    @(posedge clk);
    txs <= 0;
    @(posedge clk);
  endtask : lb_strobe

  // one nibble short of the depth gives nothing, the full depth gives data
  task lb_run(input logic [1:0] code, input logic [3:0] depth);
    apb(1, phy_specific_control_addr, {22'h0, code, 8'h00});
    lb <= 1;
    lb_feed(depth - 4'h1);
    lb_strobe;
    chk("lb early", 0, txv);
    lb_feed(1);
    lb_strobe;
    chk("lb data", 32'h11, {txv, txn});
    lb <= 0;
    @(posedge clk);
  endtask : lb_run

  task end_of_test;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(phy_specific_control_addr, 32'h0108, "ctrl rst");
    rd(interrupt_status_one_addr, 32'h0, "stat rst");
    rd(10'h3FC, 32'h0, "unmapped");
    chk("slverr", 1, e);
    pd_req <= 1;
    settle;
    chk("power down", 1, pd);
    chk("pin idle", 1, pin_out);
    pd_req <= 0;
    ev[5] <= 1;
    settle;
    rd(interrupt_status_one_addr, 32'h2000, "link ev");
    rd(interrupt_status_one_addr, 32'h0, "cleared");
    for (int i = 7; i >= 0; i--)
      if (i != 5)
      begin
        ev[i] <= ~ev[i];
        settle;
        rd(interrupt_status_one_addr, 32'h1 << (i + 8), "ev");
      end
    apb(1, phy_specific_control_addr, 32'h010B);
    apb(1, interrupt_status_one_addr, 32'h20);
    ev[5] <= 0;
    settle;
    chk("irq", 0, pin_out);
    chk("pin level", 0, pin);
    rd(interrupt_status_one_addr, 32'h2020, "irq stat");
    settle;
    chk("irq off", 1, pin_out);
    apb(1, interrupt_status_one_addr, 32'h0);
    ev[5] <= 1;
    settle;
    chk("masked", 1, pin_out);
    rd(interrupt_status_one_addr, 32'h2000, "masked ev");
    apb(1, phy_specific_control_addr, 32'h010D);
    settle;
    chk("test irq", 0, pin_out);
    apb(1, phy_specific_control_addr, 32'h0105);
    settle;
    chk("low pol", 1, pin_out);
    apb(1, phy_specific_control_addr, 32'h0100);
    col_in <= 1;
    settle;
    chk("col fd", 0, col_out);
    apb(1, phy_specific_control_addr, 32'h0110);
    settle;
    chk("col fd en", 1, col_out);
    apb(1, phy_specific_control_addr, 32'h0100);
    ev[3] <= 0;
    settle;
    chk("col hd", 1, col_out);
    lb_run(2'h0, lb_depth_00);
    lb_run(2'h1, lb_depth_01);
    lb_run(2'h2, lb_depth_10);
    lb_run(2'h3, lb_depth_11);
    apb(1, phy_specific_control_addr, 32'hFFFFFFFF);
    rd(phy_specific_control_addr, 32'h031F, "ctrl rw");
    apb(1, interrupt_status_one_addr, 32'hFFFFFFFF);
    rd(interrupt_status_one_addr, 32'h08FF, "stat rw");
    end_of_test;
  end

  initial
  begin
    #100us;
    error_cnt++;
    end_of_test;
  end
endmodule : test_phy_interrupt_control
